// ---- logic/aics_config_seq.sv ----
`default_nettype none

module aics_config_seq (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// Serial port pins
	input wire logic i_cnv,
	input wire logic i_sck,
	input wire logic i_din,
	output logic o_sdo,
	output logic o_sdo_oe,
	// Selection for the conversion now due
	output logic [aics_pkg::CH_W-1:0] o_conv_pos_ch,
	output var aics_pkg::aics_neg_t o_conv_neg_kind,
	output logic [aics_pkg::CH_W-1:0] o_conv_neg_ch,
	output logic o_conv_temp,
	output logic o_conv_bipolar,
	output logic o_result_twos,
	// Analog controls
	output logic o_full_bw,
	output logic o_int_ref_en,
	output logic o_int_ref_hi,
	output logic o_int_buf_en,
	output logic o_temp_en,
	// State view
	output logic [aics_pkg::CFG_W-1:0] o_active_cfg,
	output logic o_seq_running
);
	import aics_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic frame;
	logic frame_start;
	logic cnv_rise;
	logic sck_fall;
	logic word_valid;
	logic [CFG_W-1:0] word;
	logic accept;
	logic [CFG_W-1:0] cfg_q;
	aics_seq_t seq_q;
	logic [CH_W-1:0] idx_q;
	logic with_temp_q;
	logic [CFG_W-1:0] sdo_q;
	logic pair_mode;
	logic [CH_W-1:0] sel;
	logic [CH_W-1:0] last_start;
	logic [CH_W-1:0] step;
	logic last_reached;
	logic shape_change;
	logic [CH_W-1:0] pos_d;
	logic [CH_W-1:0] neg_ch_d;
	aics_neg_t neg_kind_d;
	logic bip_d;
	logic temp_d;

	// ----------------------------------------
	// Serial receiver
	// ----------------------------------------
	aics_serial_rx #(
		.CFG_W(CFG_W)
	) u_rx (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_cnv(i_cnv),
		.i_sck(i_sck),
		.i_din(i_din),
		.o_frame(frame),
		.o_frame_start(frame_start),
		.o_cnv_rise(cnv_rise),
		.o_sck_fall(sck_fall),
		.o_word_valid(word_valid),
		.o_word(word)
	);

	// A low flag bit marks a read-only access, so its word is discarded
	assign accept = word_valid && word[OVR_BIT];

	// Setup word, replaced only by a complete flagged word
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cfg_q <= CFG_RESET;
		end else if (accept) begin
			cfg_q <= word;
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	assign pair_mode = !cfg_q[PAIR_N_BIT];
	assign sel = cfg_q[SEL_HI:SEL_LO];
	// Pairs start on even inputs, so the last pair is set by the select's top bits
	assign last_start = pair_mode ? {sel[CH_W-1:1], 1'b0} : sel;
	assign step = pair_mode ? 3'h2 : 3'h1;
	assign last_reached = idx_q >= last_start;
	assign shape_change = word[PAIR_N_BIT] != cfg_q[PAIR_N_BIT]
		|| word[SEL_HI:SEL_LO] != sel;

	// Position and mode; a write wins over a step landing in the same cycle
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			seq_q <= AICS_SEQ_IDLE;
			idx_q <= '0;
			with_temp_q <= 1'b0;
		end else if (accept) begin
			case (word[SCAN_HI:SCAN_LO])
				SCAN_TEMP, SCAN_NOTEMP: begin
					seq_q <= AICS_SEQ_CHAN;
					idx_q <= '0;
					with_temp_q <= word[SCAN_HI:SCAN_LO] == SCAN_TEMP;
				end
				SCAN_UPDATE: begin
					if (seq_q != AICS_SEQ_IDLE && shape_change) begin
						seq_q <= AICS_SEQ_CHAN;
						idx_q <= '0;
					end // Otherwise the scan keeps its place
				end
				default: begin
					seq_q <= AICS_SEQ_IDLE;
					idx_q <= '0;
				end
			endcase
		end else if (cnv_rise) begin
			case (seq_q)
				AICS_SEQ_CHAN: begin
					if (!last_reached) begin
						idx_q <= idx_q + step;
					end else if (with_temp_q) begin
						seq_q <= AICS_SEQ_TEMP;
					end else begin
						idx_q <= '0;
					end
				end
				AICS_SEQ_TEMP: begin
					seq_q <= AICS_SEQ_CHAN;
					idx_q <= '0;
				end
				default: begin
					idx_q <= '0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Multiplexer decode
	// ----------------------------------------
	always_comb begin
		temp_d = seq_q == AICS_SEQ_TEMP;
		neg_ch_d = '0;
		if (pair_mode) begin
			neg_kind_d = AICS_NEG_PAIR;
			bip_d = !cfg_q[UNI_BIT];
			if (seq_q == AICS_SEQ_CHAN) begin
				pos_d = {idx_q[CH_W-1:1], 1'b0};
				neg_ch_d = {idx_q[CH_W-1:1], 1'b1};
			end else begin
				pos_d = sel;
				neg_ch_d = sel ^ 3'h1;
			end
		end else begin
			pos_d = seq_q == AICS_SEQ_CHAN ? idx_q : sel;
			case (cfg_q[MODE_HI:MODE_LO])
				MODE_COM_BIP: begin
					neg_kind_d = AICS_NEG_COM;
					bip_d = 1'b1;
				end
				MODE_COM_UNI: begin
					neg_kind_d = AICS_NEG_COM;
					bip_d = 1'b0;
				end
				default: begin
					// Unlisted single code 011 behaves as plain ground
					neg_kind_d = AICS_NEG_GND;
					bip_d = 1'b0;
				end
			endcase
		end
		// Sensor is measured from ground as straight binary
		if (temp_d) begin
			neg_kind_d = AICS_NEG_GND;
			bip_d = 1'b0;
		end
	end

	// Registered selection presented to the converter
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_conv_pos_ch <= '0;
			o_conv_neg_kind <= AICS_NEG_GND;
			o_conv_neg_ch <= '0;
			o_conv_temp <= 1'b0;
			o_conv_bipolar <= 1'b0;
			o_result_twos <= 1'b0;
		end else begin
			o_conv_pos_ch <= pos_d;
			o_conv_neg_kind <= neg_kind_d;
			o_conv_neg_ch <= neg_ch_d;
			o_conv_temp <= temp_d;
			o_conv_bipolar <= bip_d;
			o_result_twos <= bip_d;
		end
	end

	// ----------------------------------------
	// Reference, buffer, sensor and filter
	// ----------------------------------------
	// Unlisted reference codes power everything down, the safest default
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_int_ref_en <= 1'b1;
			o_int_ref_hi <= 1'b0;
			o_int_buf_en <= 1'b1;
			o_temp_en <= 1'b1;
			o_full_bw <= 1'b0;
		end else begin
			o_full_bw <= !cfg_q[BW_BIT];
			o_int_ref_en <= cfg_q[REF_HI:REF_LO] == REF_INT_LO
				|| cfg_q[REF_HI:REF_LO] == REF_INT_HI;
			o_int_ref_hi <= cfg_q[REF_HI:REF_LO] == REF_INT_HI;
			case (cfg_q[REF_HI:REF_LO])
				REF_INT_LO, REF_EXT_BUF_TEMP: begin
					o_int_buf_en <= 1'b1;
					o_temp_en <= 1'b1;
				end
				REF_INT_HI, REF_EXT_BUF: begin
					o_int_buf_en <= 1'b1;
					o_temp_en <= 1'b0;
				end
				REF_EXT_TEMP: begin
					o_int_buf_en <= 1'b0;
					o_temp_en <= 1'b1;
				end
				default: begin
					o_int_buf_en <= 1'b0;
					o_temp_en <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Readback and state view
	// ----------------------------------------
	// Setup word out on falling edges while readback is enabled
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sdo_q <= '0;
		end else if (frame_start) begin
			sdo_q <= cfg_q[RB_BIT] ? '0 : cfg_q;
		end else if (sck_fall) begin
			sdo_q <= {sdo_q[CFG_W-2:0], 1'b0};
		end
	end

	assign o_sdo = sdo_q[CFG_W-1];
	assign o_sdo_oe = frame;
	assign o_active_cfg = cfg_q;
	assign o_seq_running = seq_q != AICS_SEQ_IDLE;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	chk_cfg_whole_word: assert property (!$stable(cfg_q) |-> $past(accept))
		else $error("setup changed without a complete word");
	chk_flag_low_ignored: assert property (word_valid && !word[OVR_BIT] |=> $stable(cfg_q))
		else $error("word with low flag was taken");
	chk_single_ground: assert property (cfg_q[MODE_HI:MODE_LO] == MODE_SINGLE_GND
		&& !temp_d |=> o_conv_neg_kind == AICS_NEG_GND && !o_conv_bipolar)
		else $error("single mode not ground referenced");
	chk_com_bipolar: assert property (cfg_q[MODE_HI:MODE_LO] == MODE_COM_BIP && !temp_d
		|=> o_conv_neg_kind == AICS_NEG_COM && o_conv_bipolar && o_result_twos)
		else $error("shared return bipolar decode wrong");
	chk_com_unipolar: assert property (cfg_q[MODE_HI:MODE_LO] == MODE_COM_UNI && !temp_d
		|=> o_conv_neg_kind == AICS_NEG_COM && !o_conv_bipolar)
		else $error("shared return unipolar decode wrong");
	chk_pair_polarity: assert property (pair_mode && !temp_d
		|=> o_conv_neg_kind == AICS_NEG_PAIR && o_conv_bipolar == !$past(cfg_q[UNI_BIT]))
		else $error("pair polarity decode wrong");
	chk_manual_pair: assert property (pair_mode && seq_q == AICS_SEQ_IDLE
		|=> o_conv_pos_ch == $past(sel) && o_conv_neg_ch == ($past(sel) ^ 3'h1))
		else $error("manual pair members wrong");
	chk_seq_step: assert property (seq_q == AICS_SEQ_CHAN && cnv_rise && !accept
		&& !last_reached |=> idx_q == 3'($past(idx_q) + $past(step)))
		else $error("scan did not advance by one slot");
	chk_seq_end: assert property (seq_q == AICS_SEQ_CHAN && cnv_rise && !accept
		&& last_reached |=> seq_q == ($past(with_temp_q) ? AICS_SEQ_TEMP : AICS_SEQ_CHAN)
		&& (with_temp_q || idx_q == 3'h0))
		else $error("scan end handling wrong");
	chk_temp_then_wrap: assert property (seq_q == AICS_SEQ_TEMP && cnv_rise && !accept
		|=> seq_q == AICS_SEQ_CHAN && idx_q == 3'h0)
		else $error("no wrap after sensor slot");
	chk_pair_even: assert property (seq_q == AICS_SEQ_CHAN && pair_mode
		|=> !o_conv_pos_ch[0] && o_conv_neg_ch == (o_conv_pos_ch | 3'h1))
		else $error("scanned pair not even positive");
	chk_seq_init: assert property (accept && word[SCAN_HI]
		|=> seq_q == AICS_SEQ_CHAN && idx_q == 3'h0)
		else $error("scan not initialised on write");
	chk_update_keeps: assert property (accept && word[SCAN_HI:SCAN_LO] == SCAN_UPDATE
		&& seq_q != AICS_SEQ_IDLE && !shape_change |=> seq_q == $past(seq_q)
		&& idx_q == $past(idx_q) && cfg_q == $past(word))
		else $error("update word disturbed the scan");
	chk_update_restart: assert property (accept && word[SCAN_HI:SCAN_LO] == SCAN_UPDATE
		&& seq_q != AICS_SEQ_IDLE && shape_change |=> seq_q == AICS_SEQ_CHAN && idx_q == 3'h0)
		else $error("shape change did not restart scan");
	chk_hiref_no_temp: assert property (cfg_q[REF_HI:REF_LO] == REF_INT_HI
		|=> !o_temp_en && o_int_ref_hi && o_int_ref_en)
		else $error("sensor on with high internal reference");
	chk_temp_binary: assert property (o_conv_temp |-> !o_result_twos
		&& o_conv_neg_kind == AICS_NEG_GND)
		else $error("sensor result not straight binary");
	chk_ext_no_buf: assert property (cfg_q[REF_HI:REF_LO] == REF_EXT
		|=> !o_int_buf_en && !o_int_ref_en)
		else $error("buffer on with external reference");
	chk_bandwidth: assert property (##1 o_full_bw == !$past(cfg_q[BW_BIT]))
		else $error("filter width not following setup");

	cov_temp_slot: cover property (seq_q == AICS_SEQ_TEMP ##1 seq_q == AICS_SEQ_CHAN);
	cov_restart: cover property (accept && word[SCAN_HI:SCAN_LO] == SCAN_UPDATE
		&& seq_q != AICS_SEQ_IDLE && shape_change);
	cov_pair_scan: cover property (seq_q == AICS_SEQ_CHAN && pair_mode && last_reached && cnv_rise);
endmodule : aics_config_seq

`default_nettype wire

// ---- logic/aics_pkg.sv ----
`default_nettype none

package aics_pkg;
	// ----------------------------------------
	// Setup word layout
	// ----------------------------------------
	localparam int CFG_W = 14;
	localparam int CH_W = 3;
	localparam int OVR_BIT = 13;
	localparam int MODE_HI = 12;
	localparam int MODE_LO = 10;
	localparam int PAIR_N_BIT = 11;
	localparam int UNI_BIT = 12;
	localparam int SEL_HI = 9;
	localparam int SEL_LO = 7;
	localparam int BW_BIT = 6;
	localparam int REF_HI = 5;
	localparam int REF_LO = 3;
	localparam int SCAN_HI = 2;
	localparam int SCAN_LO = 1;
	localparam int RB_BIT = 0;
	// Flag set, single ground, last channel 7, quarter width, scan off
	localparam logic [CFG_W-1:0] CFG_RESET = 14'h3FC1;

	// ----------------------------------------
	// Field codes
	// ----------------------------------------
	localparam logic [2:0] MODE_SINGLE_GND = 3'h7;
	localparam logic [2:0] MODE_COM_BIP = 3'h2;
	localparam logic [2:0] MODE_COM_UNI = 3'h6;
	localparam logic [1:0] SCAN_OFF = 2'h0;
	localparam logic [1:0] SCAN_UPDATE = 2'h1;
	localparam logic [1:0] SCAN_TEMP = 2'h2;
	localparam logic [1:0] SCAN_NOTEMP = 2'h3;
	localparam logic [2:0] REF_INT_LO = 3'h0;
	localparam logic [2:0] REF_INT_HI = 3'h1;
	localparam logic [2:0] REF_EXT_TEMP = 3'h2;
	localparam logic [2:0] REF_EXT_BUF_TEMP = 3'h3;
	localparam logic [2:0] REF_EXT_BUF = 3'h6;
	localparam logic [2:0] REF_EXT = 3'h7;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {AICS_NEG_GND, AICS_NEG_COM, AICS_NEG_PAIR} aics_neg_t;
	typedef enum logic [1:0] {AICS_SEQ_IDLE, AICS_SEQ_CHAN, AICS_SEQ_TEMP} aics_seq_t;
endpackage : aics_pkg

`default_nettype wire

// ---- logic/aics_serial_rx.sv ----
`default_nettype none

module aics_serial_rx #(
	parameter int CFG_W = aics_pkg::CFG_W
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// Serial pins, asynchronous to i_mclk
	input wire logic i_cnv,
	input wire logic i_sck,
	input wire logic i_din,
	// Frame events
	output logic o_frame,
	output logic o_frame_start,
	output logic o_cnv_rise,
	output logic o_sck_fall,
	// Received word
	output logic o_word_valid,
	output logic [CFG_W-1:0] o_word
);
	import aics_pkg::*;

	localparam int CNT_W = $clog2(CFG_W + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CFG_W - 1);
	localparam logic [CNT_W-1:0] CNT_DONE = CNT_W'(CFG_W);

	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	logic [2:0] dly_q;
	logic cnv_s;
	logic din_s;
	logic sck_rise;
	logic [CNT_W-1:0] cnt_q;
	logic [CFG_W-2:0] shift_q;

	// ----------------------------------------
	// Pin synchronisers, bit 2 conversion, 1 clock, 0 data
	// ----------------------------------------
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync1_q <= 3'h4;
			sync2_q <= 3'h4;
			dly_q <= 3'h4;
		end else begin
			sync1_q <= {i_cnv, i_sck, i_din};
			sync2_q <= sync1_q;
			dly_q <= sync2_q;
		end
	end

	// Edges; data and clock share the same delay so they stay aligned
	assign cnv_s = sync2_q[2];
	assign din_s = sync2_q[0];
	assign sck_rise = sync2_q[1] & ~dly_q[1] & ~cnv_s;
	assign o_sck_fall = ~sync2_q[1] & dly_q[1] & ~cnv_s;
	assign o_cnv_rise = cnv_s & ~dly_q[2];
	assign o_frame_start = ~cnv_s & dly_q[2];
	assign o_frame = ~cnv_s;

	// Bit counter; conversion high ends the frame and drops a partial word
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q <= '0;
			shift_q <= '0;
		end else if (cnv_s) begin
			cnt_q <= '0;
		end else if (sck_rise && cnt_q != CNT_DONE) begin
			cnt_q <= cnt_q + 1'b1;
			shift_q <= {shift_q[CFG_W-3:0], din_s};
		end
	end

	// Word out on the last of the first 14 rising edges; later edges ignored
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_word_valid <= 1'b0;
			o_word <= '0;
		end else begin
			o_word_valid <= sck_rise && cnt_q == CNT_LAST;
			if (sck_rise && cnt_q == CNT_LAST) begin
				o_word <= {shift_q, din_s};
			end
		end
	end

	chk_word_on_last_edge: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		o_word_valid |-> $past(cnt_q) == CNT_LAST && $past(sck_rise))
		else $error("word valid without fourteenth rising edge");
	chk_word_single_pulse: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		o_word_valid |=> !o_word_valid)
		else $error("word valid longer than one cycle");
endmodule : aics_serial_rx

`default_nettype wire

// ---- testbench/aics_host_model.sv ----
`default_nettype none

module aics_host_model (
	// Clock
	input wire logic i_mclk,
	// Serial pins towards the device
	output var logic o_cnv,
	output var logic o_sck,
	output var logic o_din,
	// Readback from the device
	input wire logic i_sdo
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	// Serial half period, kept well above the device's sync delay
	localparam int HALF = 4;

	// Word seen on the readback line during the last access
	logic [13:0] rd_word;

	// Idle levels; sck stands still outside frames
	initial begin
		o_cnv = 1'b0;
		o_sck = 1'b0;
		o_din = 1'b1;
		rd_word = '0;
	end

	// Step just after the clock edge, always by the same delay
	task automatic tick(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask : tick

	// One access; the opening cnv rise closes any older frame
	task automatic send_word(input logic [13:0] w, input int n);
		int i;
		rd_word = '0;
		o_cnv = 1'b1;
		o_din = ~o_din; // Deselected: no stale value on the line
		tick(HALF);
		o_cnv = 1'b0;
		o_din = 1'b0;
		tick(HALF);
		for (i = 0; i < n; i++) begin
			o_din = (i < 14) ? w[13-i] : 1'b1; // MSB first, extras must be ignored
			tick(HALF);
			// Readback settles three clocks after each fall, one clock before this rise
			if (i < 14) begin
				rd_word = {rd_word[12:0], i_sdo};
			end
			o_sck = 1'b1;
			tick(HALF);
			o_sck = 1'b0;
		end
		o_din = 1'b0; // Held low so no new word starts
		tick(8);
	endtask : send_word

	// Conversion start pulse, then an empty frame with din low
	task automatic convert();
		o_cnv = 1'b1;
		o_din = 1'b1;
		tick(HALF);
		o_cnv = 1'b0;
		o_din = 1'b0;
		tick(HALF);
	endtask : convert
endmodule : aics_host_model

`default_nettype wire

// ---- testbench/testbench.sv ----
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import aics_pkg::*;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam int LIMIT = 20000;
	logic mclk, rst_n, sdo, sdo_oe, temp, bip, twos, full_bw;
	logic ref_en, ref_hi, buf_en, temp_en, running;
	wire logic cnv, sck, din;
	logic [CH_W-1:0] pos_ch, neg_ch;
	aics_neg_t neg_kind;
	logic [CFG_W-1:0] cfg;
	int err_count, compares, cycles;

	// Device and host
	aics_config_seq i_dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_cnv(cnv), .i_sck(sck),
		.i_din(din), .o_sdo(sdo), .o_sdo_oe(sdo_oe), .o_conv_pos_ch(pos_ch),
		.o_conv_neg_kind(neg_kind), .o_conv_neg_ch(neg_ch), .o_conv_temp(temp),
		.o_conv_bipolar(bip), .o_result_twos(twos), .o_full_bw(full_bw),
		.o_int_ref_en(ref_en), .o_int_ref_hi(ref_hi), .o_int_buf_en(buf_en),
		.o_temp_en(temp_en), .o_active_cfg(cfg), .o_seq_running(running));
	aics_host_model i_host (.i_mclk(mclk), .o_cnv(cnv), .o_sck(sck), .o_din(din),
		.i_sdo(sdo));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// Flagged word, readback off
	function automatic logic [13:0] mk(input logic [2:0] m, input logic [2:0] s,
		input logic b, input logic [2:0] r, input logic [1:0] q);
		return {1'b1, m, s, b, r, q, 1'b1};
	endfunction : mk

	task automatic summarize();
		if (err_count == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_reset();
		check(cfg, CFG_RESET);
		check(pos_ch, 3'h7);
		check(neg_kind, AICS_NEG_GND);
		check(full_bw, 1'b0);
		check(running, 1'b0);
	endtask : test_reset

	// Every input code, both select parities in pair modes
	task automatic test_modes();
		logic [2:0] c;
		logic [13:0] w;
		logic pr;
		for (int i = 0; i < 8; i++) begin
			c = i[2:0];
			w = mk(c, {2'b00, c[0]}, c[1], REF_EXT_TEMP, SCAN_OFF);
			i_host.send_word(w, 14);
			pr = !c[1];
			check(cfg, w);
			check(neg_kind, pr ? AICS_NEG_PAIR : (c[1:0] == 2'h2 ? AICS_NEG_COM : AICS_NEG_GND));
			check(pos_ch, {2'b00, c[0]});
			check(neg_ch, pr ? {2'b00, !c[0]} : 3'h0);
			check(bip, c == 3'h2 || c[2:1] == 2'h0);
			check(twos, c == 3'h2 || c[2:1] == 2'h0);
			check(full_bw, !c[1]);
		end
	endtask : test_modes

	// Every reference code
	task automatic test_refs();
		logic [2:0] r;
		for (int i = 0; i < 8; i++) begin
			r = i[2:0];
			i_host.send_word(mk(MODE_SINGLE_GND, 3'h0, 1'b0, r, SCAN_OFF), 14);
			check(temp_en, r == 3'h0 || r == 3'h2 || r == 3'h3);
			check(ref_en, r < 3'h2);
			check(ref_hi, r == 3'h1);
			check(buf_en, r == 3'h0 || r == 3'h1 || r == 3'h3 || r == 3'h6);
		end
	endtask : test_refs

	// Short frame, read-only frame, over-long frame
	task automatic test_partial();
		logic [13:0] prev, w;
		prev = mk(MODE_SINGLE_GND, 3'h0, 1'b0, REF_EXT, SCAN_OFF);
		w = mk(MODE_COM_UNI, 3'h4, 1'b1, REF_INT_LO, SCAN_OFF);
		i_host.send_word(w, 10);
		check(cfg, prev);
		i_host.send_word({1'b0, w[12:0]}, 14);
		check(cfg, prev);
		i_host.send_word(w, 16);
		check(cfg, w);
		check(neg_kind, AICS_NEG_COM);
	endtask : test_partial

	// Singles up to 3 with the sensor slot, bipolar setting
	task automatic test_seq_temp();
		i_host.send_word(mk(MODE_COM_BIP, 3'h3, 1'b0, REF_EXT_TEMP, SCAN_TEMP), 14);
		check(running, 1'b1);
		check(pos_ch, 3'h0);
		for (int k = 1; k < 4; k++) begin
			i_host.convert();
			check(pos_ch, k[2:0]);
			check(temp, 1'b0);
		end
		i_host.convert();
		check(temp, 1'b1);
		check(twos, 1'b0);
		check(neg_kind, AICS_NEG_GND);
		i_host.convert();
		check(temp, 1'b0);
		check(pos_ch, 3'h0);
	endtask : test_seq_temp

	// Pairs up to odd last channel 5, no sensor slot
	task automatic test_seq_pairs();
		logic [2:0] p;
		i_host.send_word(mk(3'h0, 3'h5, 1'b0, REF_INT_LO, SCAN_NOTEMP), 14);
		for (int k = 0; k < 4; k++) begin
			p = 3'((k % 3) * 2);
			check(pos_ch, p);
			check(neg_ch, p + 3'h1);
			check(neg_kind, AICS_NEG_PAIR);
			check(temp, 1'b0);
			i_host.convert();
		end
	endtask : test_seq_pairs

	// Update in flight, keep place, then restart on a new last channel
	task automatic test_update();
		i_host.send_word(mk(3'h0, 3'h5, 1'b1, REF_INT_LO, SCAN_UPDATE), 14);
		check(pos_ch, 3'h4);
		check(running, 1'b1);
		check(full_bw, 1'b0);
		i_host.convert();
		i_host.send_word(mk(3'h0, 3'h3, 1'b1, REF_INT_LO, SCAN_UPDATE), 14);
		check(pos_ch, 3'h0);
		check(running, 1'b1);
	endtask : test_update

	// Setup word read back while enabled, zeros once disabled
	task automatic test_readback();
		logic [13:0] w;
		w = {1'b1, MODE_SINGLE_GND, 3'h2, 1'b0, REF_EXT, SCAN_OFF, 1'b0};
		i_host.send_word(w, 14);
		check(cfg, w);
		check(running, 1'b0);
		i_host.send_word(14'h0000, 14);
		check(i_host.rd_word, w);
		check(sdo_oe, 1'b1);
		check(cfg, w);
		i_host.send_word(mk(MODE_SINGLE_GND, 3'h2, 1'b0, REF_EXT, SCAN_OFF), 14);
		check(i_host.rd_word, w);
		i_host.send_word(14'h0000, 14);
		check(i_host.rd_word, 14'h0000);
	endtask : test_readback

	// Reset in mid-run, with a scan going and a frame left half shifted
	task automatic test_midreset();
		logic [13:0] w;
		w = mk(MODE_COM_BIP, 3'h1, 1'b0, REF_EXT_TEMP, SCAN_OFF);
		i_host.send_word(mk(MODE_SINGLE_GND, 3'h5, 1'b0, REF_EXT_TEMP, SCAN_TEMP), 14);
		check(running, 1'b1);
		i_host.send_word(w, 10);
		rst_n = 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		repeat (4) @(posedge mclk);
		#1;
		check(cfg, CFG_RESET);
		check(running, 1'b0);
		check(pos_ch, 3'h7);
		check(temp_en, 1'b1);
		i_host.send_word(w, 14);
		check(cfg, w);
		check(neg_kind, AICS_NEG_COM);
		check(bip, 1'b1);
		check(pos_ch, 3'h1);
	endtask : test_midreset

	// ----------------------------------------
	// Clock, reset, sequence, timeout
	// ----------------------------------------
	always #5 mclk = ~mclk;

	// Hang guard, well above the expected run length
	always @(posedge mclk) begin
		cycles++;
		if (cycles == LIMIT) begin
			err_count++;
			summarize();
		end
	end

	// Main sequence
	initial begin
		mclk = 1'b0;
		rst_n = 1'b0;
		err_count = 0;
		compares = 0;
		cycles = 0;
		repeat (6) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		repeat (4) @(posedge mclk);
		#1;
		test_reset();
		test_modes();
		test_refs();
		test_partial();
		test_seq_temp();
		test_seq_pairs();
		test_update();
		test_readback();
		test_midreset();
		summarize();
	end
endmodule : testbench

`default_nettype wire
